// ---- hw/gpt_unit_regs.vh ----
/*
 * Constants of the general purpose timer unit: register offsets, control
 * field positions, mode codes, reset values and prescaler timing.
 * Assumes it is included by bare name by the design file.
 */
// Overview of operation
// - Five 16-bit up/down timers: three in module one, two plus capture reg.
// - Timers run alone or chain, only to a timer of their own module.
// - Module one timers each select timer, gated timer or counter mode.
// - Timer mode counts prescaled clock; counter mode counts input pin events.
// - Gated mode counts prescaled clock only while the input pin is at gate level.
// - Module one finest period is eight CPU clocks, 400 ns at 20 MHz.
// - Software sets direction; a direction pin may optionally invert it live.
// - Core and second aux timer toggle latches invert on each over/underflow.
// - Toggle latches drive output pins; the core latch can clock the aux timers.
// - An aux timer in capture or reload configuration does not count.
// - Capture: aux input pin trigger copies core timer into that aux timer.
// - Reload: core loads from aux on pin event or chosen latch transition.
// - Both aux on opposite latch transitions alternate reloads, making PWM.
// - Module two finest period is four CPU clocks, 200 ns at 20 MHz.
// - Module two timers count prescaled clock or external input events.
// - Module two core latch toggles on over/underflow, clocks aux, drives pin.
// - Module two core over/underflow pulses compare timers, may reload it.
// - Capture pin edge copies module two aux timer; optionally clears it.
`ifndef GPT_UNIT_REGS_VH
`define GPT_UNIT_REGS_VH

// ==========================================================================
// Register byte offsets
`define CTRL_OFF     8'h00
`define CNT_OFF      8'h20
`define CAPTURE_RELOAD_REGISTER_OFF   8'h40
`define IRQ_STAT_OFF 8'h44
`define IRQ_MASK_OFF 8'h48
`define PIN_STAT_OFF 8'h4C

// ==========================================================================
// Control word fields
`define PRESC_LSB    0
`define MODE_LSB     3
`define RUN_BIT      6
`define DOWN_BIT     7
`define EXTDIR_BIT   8
`define EDGE_LSB     9
`define TOUT_EN_BIT  11
`define CHAIN_BIT    12
`define RLD_EN_BIT   12
`define TRIG_LSB     13
`define CLR_BIT      13
`define CAPEDGE_LSB  14

// ==========================================================================
// Mode codes
`define MODE_TIMER   3'h0
`define MODE_COUNTER 3'h1
`define MODE_GATE_LO 3'h2
`define MODE_GATE_HI 3'h3
`define MODE_RELOAD  3'h4
`define MODE_CAPTURE 3'h5

// Reload trigger codes.
`define TRIG_PIN     2'h1
`define TRIG_RISE    2'h2
`define TRIG_FALL    2'h3

// ==========================================================================
// Reset values and bus answers
`define CTRL_RST     16'h0000
`define CNT_RST      16'h0000
`define CNT_MAX      16'hFFFF
`define CNT_ONE      16'h0001
`define IRQ_RST      6'h00
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

// ==========================================================================
// Prescaler timing, counted in CPU clock cycles
`define REF_CLK_MHZ  20
`define FIRST_TIMER_MODULE_MIN_NS  400
`define SECOND_TIMER_MODULE_MIN_NS  200
`define FIRST_TIMER_MODULE_BASE_DIV ((`FIRST_TIMER_MODULE_MIN_NS * `REF_CLK_MHZ) / 1000)
`define SECOND_TIMER_MODULE_BASE_DIV ((`SECOND_TIMER_MODULE_MIN_NS * `REF_CLK_MHZ) / 1000)

`endif

// ---- hw/general_purpose_timer_unit.v ----
/*
 * General purpose timer unit: five 16-bit timers in two modules, with
 * prescalers, toggle latches, capture/reload and an AXI4-Lite slave.
 * Assumes one clock; all pins are asynchronous and get synchronised here.
 * Index map: 0 first aux, 1 first core, 2 second aux of module one,
 * 3 module two aux, 4 module two core.
 */
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`include "gpt_unit_regs.vh"

module general_purpose_timer_unit (
    input wire clock,
    input wire sys_rst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [4:0] timer_input_pin,
    input wire [4:0] direction_input_pin,
    input wire capture_trigger_pin,
    output wire core_toggle_output_pin,
    output wire aux_toggle_output_pin,
    output wire second_core_toggle_pin,
    output wire compare_unit_count_pulse,
    output wire irq
);

// ==========================================================================
// Helper functions

function presc_tick;
    input [15:0] free;
    input [15:0] div;
    input [2:0] sel;
    reg [15:0] m;
    begin
        m = (div << sel) - `CNT_ONE;
        presc_tick = ((free & m) == m);
    end
endfunction

function edge_hit;
    input [1:0] sel;
    input cur;
    input prev;
    begin
        edge_hit = (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
    end
endfunction

function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] strb;
    begin
        merge16 = {strb[1] ? wd[15:8] : old[15:8],
                   strb[0] ? wd[7:0] : old[7:0]};
    end
endfunction

// ==========================================================================
// State

reg [15:0] cnt_ff [0:4];
reg [15:0] ctrl_ff [0:4];
reg [15:0] capture_reload_register_ff;
reg [2:0] lat_ff;
reg [2:0] lat_p_ff;
reg [15:0] free_ff;
reg [5:0] irq_stat_ff;
reg [5:0] irq_mask_ff;
reg irq_ff;
reg [4:0] tin_m_ff, tin_s_ff, tin_p_ff;
reg [4:0] dir_m_ff, dir_s_ff;
reg cap_m_ff, cap_s_ff, cap_p_ff;
reg [2:0] pin_ff;
reg pulse_ff;

reg aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff;
reg arready_ff, rvalid_ff;
reg [7:0] waddr_ff;
reg [31:0] wdata_ff, rdata_ff;
reg [3:0] wstrb_ff;
reg [1:0] bresp_ff, rresp_ff;

reg [15:0] nxt_cnt [0:4];
reg [4:0] en, ovf, down, in_edge, rld, cap;
reg [2:0] md, trig;
reg chain_ev, core_rise, core_fall, cap_evt;
reg [5:0] nxt_irq_stat;
reg [2:0] nxt_lat;
reg wr_hit;
reg [31:0] rd_val;
reg rd_hit;
integer i;

wire aw_take = s_axi_awvalid & awready_ff;
wire w_take = s_axi_wvalid & wready_ff;
wire ar_take = s_axi_arvalid & arready_ff;
wire do_wr = aw_full_ff & w_full_ff & ~bvalid_ff;
wire nxt_aw_full = (aw_full_ff | aw_take) & ~do_wr;
wire nxt_w_full = (w_full_ff | w_take) & ~do_wr;
wire nxt_bvalid = do_wr | (bvalid_ff & ~s_axi_bready);
wire nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);

// ==========================================================================
// Count enables, overflows and trigger events

always @*
begin
    for (i = 0; i < 5; i = i + 1)
    begin
        md = ctrl_ff[i][`MODE_LSB +: 3];
        down[i] = ctrl_ff[i][`DOWN_BIT] ^
                  (ctrl_ff[i][`EXTDIR_BIT] & dir_s_ff[i]);
        in_edge[i] = edge_hit(ctrl_ff[i][`EDGE_LSB +: 2],
                              tin_s_ff[i], tin_p_ff[i]);
        // Chaining only reaches a latch of the timer's own module.
        if (i == 3)
            chain_ev = edge_hit(ctrl_ff[i][`EDGE_LSB +: 2],
                                lat_ff[2], lat_p_ff[2]);
        else
            chain_ev = edge_hit(ctrl_ff[i][`EDGE_LSB +: 2],
                                lat_ff[0], lat_p_ff[0]);
        en[i] = 1'b0;
        if (ctrl_ff[i][`RUN_BIT])
        begin
            case (md)
                `MODE_TIMER:
                    en[i] = presc_tick(free_ff, (i < 3) ?
                        `FIRST_TIMER_MODULE_BASE_DIV : `SECOND_TIMER_MODULE_BASE_DIV,
                        ctrl_ff[i][`PRESC_LSB +: 3]);
                `MODE_COUNTER:
                    en[i] = ((i == 0 || i == 2 || i == 3) &&
                             ctrl_ff[i][`CHAIN_BIT]) ?
                            chain_ev : in_edge[i];
                `MODE_GATE_LO:
                    en[i] = presc_tick(free_ff, (i < 3) ?
                        `FIRST_TIMER_MODULE_BASE_DIV : `SECOND_TIMER_MODULE_BASE_DIV,
                        ctrl_ff[i][`PRESC_LSB +: 3]) &
                        ~tin_s_ff[i];
                `MODE_GATE_HI:
                    en[i] = presc_tick(free_ff, (i < 3) ?
                        `FIRST_TIMER_MODULE_BASE_DIV : `SECOND_TIMER_MODULE_BASE_DIV,
                        ctrl_ff[i][`PRESC_LSB +: 3]) &
                        tin_s_ff[i];
                default:
                    en[i] = 1'b0;
            endcase
        end
        ovf[i] = en[i] & (down[i] ? (cnt_ff[i] == `CNT_RST) :
                                    (cnt_ff[i] == `CNT_MAX));
    end
    // The core latch edge is taken from the overflow itself, so a reload
    // lands in the same cycle the latch flips.
    core_rise = ovf[1] & ~lat_ff[0];
    core_fall = ovf[1] & lat_ff[0];
    rld = 5'h00;
    cap = 5'h00;
    for (i = 0; i < 5; i = i + 1)
    begin
        md = ctrl_ff[i][`MODE_LSB +: 3];
        trig = {1'b0, ctrl_ff[i][`TRIG_LSB +: 2]};
        if ((i == 0 || i == 2) && md == `MODE_RELOAD)
            rld[i] = (trig[1:0] == `TRIG_PIN && in_edge[i]) ||
                     (trig[1:0] == `TRIG_RISE && core_rise) ||
                     (trig[1:0] == `TRIG_FALL && core_fall);
        if ((i == 0 || i == 2) && md == `MODE_CAPTURE)
            cap[i] = in_edge[i];
    end
    cap_evt = edge_hit(ctrl_ff[3][`CAPEDGE_LSB +: 2],
                       cap_s_ff, cap_p_ff);
end

// ==========================================================================
// Next counter values; a software write to a counter has the last word

always @*
begin
    for (i = 0; i < 5; i = i + 1)
    begin
        nxt_cnt[i] = cnt_ff[i];
        if (en[i])
            nxt_cnt[i] = down[i] ? cnt_ff[i] - `CNT_ONE :
                                   cnt_ff[i] + `CNT_ONE;
        if (cap[i])
            nxt_cnt[i] = cnt_ff[1];
        if (do_wr && waddr_ff == `CNT_OFF + {i[5:0], 2'b00})
            nxt_cnt[i] = merge16(cnt_ff[i], wdata_ff, wstrb_ff);
    end
    // Reload wins over the count of the same cycle.
    if (rld[0])
        nxt_cnt[1] = cnt_ff[0];
    else if (rld[2])
        nxt_cnt[1] = cnt_ff[2];
    if (ovf[4] && ctrl_ff[4][`RLD_EN_BIT])
        nxt_cnt[4] = capture_reload_register_ff;
    if (cap_evt && ctrl_ff[3][`CLR_BIT])
        nxt_cnt[3] = `CNT_RST;
    if (do_wr && waddr_ff == `CNT_OFF + 8'h04)
        nxt_cnt[1] = merge16(cnt_ff[1], wdata_ff, wstrb_ff);
    if (do_wr && waddr_ff == `CNT_OFF + 8'h0C)
        nxt_cnt[3] = merge16(cnt_ff[3], wdata_ff, wstrb_ff);
    if (do_wr && waddr_ff == `CNT_OFF + 8'h10)
        nxt_cnt[4] = merge16(cnt_ff[4], wdata_ff, wstrb_ff);
    nxt_lat = lat_ff ^ {ovf[4], ovf[2], ovf[1]};
    // A new event beats a write-one-to-clear in the same cycle.
    nxt_irq_stat = irq_stat_ff;
    if (do_wr && waddr_ff == `IRQ_STAT_OFF)
        nxt_irq_stat = irq_stat_ff & ~wdata_ff[5:0];
    nxt_irq_stat = nxt_irq_stat | {cap_evt, ovf};
    wr_hit = (waddr_ff[7:5] == 3'h0 && waddr_ff[4:2] < 3'h5) ||
             (waddr_ff[7:5] == 3'h1 && waddr_ff[4:2] < 3'h5) ||
             waddr_ff == `CAPTURE_RELOAD_REGISTER_OFF || waddr_ff == `IRQ_STAT_OFF ||
             waddr_ff == `IRQ_MASK_OFF || waddr_ff == `PIN_STAT_OFF;
end

// ==========================================================================
// Read decode

always @*
begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    if (s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[4:2] < 3'h5)
        rd_val = {16'h0000, ctrl_ff[s_axi_araddr[4:2]]};
    else if (s_axi_araddr[7:5] == 3'h1 && s_axi_araddr[4:2] < 3'h5)
        rd_val = {16'h0000, cnt_ff[s_axi_araddr[4:2]]};
    else if (s_axi_araddr == `CAPTURE_RELOAD_REGISTER_OFF)
        rd_val = {16'h0000, capture_reload_register_ff};
    else if (s_axi_araddr == `IRQ_STAT_OFF)
        rd_val = {26'h0000000, irq_stat_ff};
    else if (s_axi_araddr == `IRQ_MASK_OFF)
        rd_val = {26'h0000000, irq_mask_ff};
    else if (s_axi_araddr == `PIN_STAT_OFF)
        rd_val = {18'h00000, cap_s_ff, lat_ff, dir_s_ff, tin_s_ff};
    else
        rd_hit = 1'b0;
end

// ==========================================================================
// Clocked state

always @(posedge clock)
begin
    if (sys_rst)
    begin
        for (i = 0; i < 5; i = i + 1)
        begin
            cnt_ff[i] <= `CNT_RST;
            ctrl_ff[i] <= `CTRL_RST;
        end
        capture_reload_register_ff <= `CNT_RST;
        lat_ff <= 3'h0;
        lat_p_ff <= 3'h0;
        free_ff <= `CNT_RST;
        irq_stat_ff <= `IRQ_RST;
        irq_mask_ff <= `IRQ_RST;
        irq_ff <= 1'b0;
        tin_m_ff <= 5'h00;
        tin_s_ff <= 5'h00;
        tin_p_ff <= 5'h00;
        dir_m_ff <= 5'h00;
        dir_s_ff <= 5'h00;
        cap_m_ff <= 1'b0;
        cap_s_ff <= 1'b0;
        cap_p_ff <= 1'b0;
        pin_ff <= 3'h0;
        pulse_ff <= 1'b0;
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        awready_ff <= 1'b0;
        wready_ff <= 1'b0;
        bvalid_ff <= 1'b0;
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b0;
        waddr_ff <= 8'h00;
        wdata_ff <= 32'h00000000;
        wstrb_ff <= 4'h0;
        bresp_ff <= `RESP_OKAY;
        rresp_ff <= `RESP_OKAY;
        rdata_ff <= 32'h00000000;
    end
    else
    begin
        for (i = 0; i < 5; i = i + 1)
        begin
            cnt_ff[i] <= nxt_cnt[i];
            if (do_wr && waddr_ff == `CTRL_OFF + {i[5:0], 2'b00})
                ctrl_ff[i] <= merge16(ctrl_ff[i], wdata_ff, wstrb_ff);
        end
        if (cap_evt)
            capture_reload_register_ff <= cnt_ff[3];
        else if (do_wr && waddr_ff == `CAPTURE_RELOAD_REGISTER_OFF)
            capture_reload_register_ff <= merge16(capture_reload_register_ff, wdata_ff, wstrb_ff);
        lat_ff <= nxt_lat;
        lat_p_ff <= lat_ff;
        free_ff <= free_ff + `CNT_ONE;
        irq_stat_ff <= nxt_irq_stat;
        if (do_wr && waddr_ff == `IRQ_MASK_OFF)
            irq_mask_ff <= wdata_ff[5:0];
        irq_ff <= |(nxt_irq_stat & irq_mask_ff);
        // Two stages before use; the third only feeds edge detection.
        tin_m_ff <= timer_input_pin;
        tin_s_ff <= tin_m_ff;
        tin_p_ff <= tin_s_ff;
        dir_m_ff <= direction_input_pin;
        dir_s_ff <= dir_m_ff;
        cap_m_ff <= capture_trigger_pin;
        cap_s_ff <= cap_m_ff;
        cap_p_ff <= cap_s_ff;
        pin_ff[0] <= nxt_lat[0] & ctrl_ff[1][`TOUT_EN_BIT];
        pin_ff[1] <= nxt_lat[1] & ctrl_ff[2][`TOUT_EN_BIT];
        pin_ff[2] <= nxt_lat[2] & ctrl_ff[4][`TOUT_EN_BIT];
        pulse_ff <= ovf[4];
        aw_full_ff <= nxt_aw_full;
        w_full_ff <= nxt_w_full;
        awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
        wready_ff <= ~nxt_w_full & ~nxt_bvalid;
        bvalid_ff <= nxt_bvalid;
        if (aw_take)
            waddr_ff <= {s_axi_awaddr[7:2], 2'b00};
        if (w_take)
        begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
        if (do_wr)
            bresp_ff <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        arready_ff <= ~nxt_rvalid;
        rvalid_ff <= nxt_rvalid;
        if (ar_take)
        begin
            rdata_ff <= rd_val;
            rresp_ff <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
    end
end

assign s_axi_awready = awready_ff;
assign s_axi_wready = wready_ff;
assign s_axi_bresp = bresp_ff;
assign s_axi_bvalid = bvalid_ff;
assign s_axi_arready = arready_ff;
assign s_axi_rdata = rdata_ff;
assign s_axi_rresp = rresp_ff;
assign s_axi_rvalid = rvalid_ff;
assign core_toggle_output_pin = pin_ff[0];
assign aux_toggle_output_pin = pin_ff[1];
assign second_core_toggle_pin = pin_ff[2];
assign compare_unit_count_pulse = pulse_ff;
assign irq = irq_ff;

endmodule

// ---- test/gpt_unit_asserts.sv ----
/*
 * Checker for the timer unit: bus handshakes, read data and interrupt.
 * Assumes it is bound to the unit's top module, which has one clock.
 */
`timescale 1ns/100ps

module gpt_unit_asserts (
    input wire clock,
    input wire sys_rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire compare_unit_count_pulse,
    input wire irq
);
    // ======================================================================
    // Bus and interrupt properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("late b");
    AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("late r");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during r");
    AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready &&
        !s_axi_wready) else $error("write taken during b");
    AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
        s_axi_rdata == 32'h0) else $error("error read not zero");
    AST_UPPER_ZERO: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper half not zero");
    AST_IRQ_CLEAR: assert property (
        $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("irq fell without a write");

    C_WRITE: cover property (s_axi_bvalid && s_axi_bready);
    C_READ: cover property (s_axi_rvalid && s_axi_rready);
    C_IRQ: cover property ($rose(irq));
    C_PULSE: cover property (compare_unit_count_pulse);
endmodule

bind general_purpose_timer_unit gpt_unit_asserts u_chk (.clock, .sys_rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .compare_unit_count_pulse, .irq);

// ---- test/gpt_pin_model.sv ----
/*
 * Model of the external count, gate, direction and capture pins.
 * Assumes the bench sets the wanted levels just after a clock edge.
 */
`timescale 1ns/100ps

module gpt_pin_model (
    input wire clock,
    input wire [4:0] tin_req,
    input wire [4:0] dir_req,
    input wire cap_req,
    output reg [4:0] timer_input_pin = 5'h00,
    output reg [4:0] direction_input_pin = 5'h00,
    output reg capture_trigger_pin = 1'b0
);
    // ======================================================================
    // Pin drivers
    // Pins move one edge after a request, like a real pad driven off-chip.
    always @(posedge clock)
    begin
        timer_input_pin <= tin_req;
        direction_input_pin <= dir_req;
        capture_trigger_pin <= cap_req;
    end
endmodule

// ---- test/tb.sv ----
/*
 * Self-checking bench for the timer unit, driven over its register bus.
 * Assumes the unit's constants header and the pin model are compiled.
 */
`timescale 1ns/100ps
`include "gpt_unit_regs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end

module tb;
    reg clock = 1'b0;
    reg sys_rst = 1'b1;
    reg [7:0] awa = 8'h00;
    reg [7:0] ara = 8'h00;
    reg [31:0] wd = 32'h0;
    reg awv = 1'b0;
    reg wv = 1'b0;
    reg arv = 1'b0;
    reg [4:0] tin = 5'h00;
    reg [4:0] dir = 5'h00;
    reg cap = 1'b0;
    wire awr, wrdy, bv, arr, rv, t3o, t4o, t6o, cpul, irq, cpin;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [4:0] tpin, dpin;
    integer errors = 0;
    integer checks = 0;
    integer i;
    reg [31:0] v;
    reg [1:0] r;

    // ======================================================================
    // Clock, design and pins
    always #4 clock = ~clock;

    general_purpose_timer_unit DUT (.clock(clock), .sys_rst(sys_rst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(1'b1), .timer_input_pin(tpin),
        .direction_input_pin(dpin), .capture_trigger_pin(cpin),
        .core_toggle_output_pin(t3o), .aux_toggle_output_pin(t4o),
        .second_core_toggle_pin(t6o), .compare_unit_count_pulse(cpul),
        .irq(irq));

    gpt_pin_model u_pins (.clock(clock), .tin_req(tin), .dir_req(dir),
        .cap_req(cap), .timer_input_pin(tpin),
        .direction_input_pin(dpin), .capture_trigger_pin(cpin));

    // ======================================================================
    // Tasks
    task finish_test;
    begin
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    task tmo(input integer n);
        if (n >= 200)
        begin
            errors++;
            finish_test;
        end
    endtask

    function [7:0] ctl(input [2:0] k);
        ctl = `CTRL_OFF + {3'h0, k, 2'h0};
    endfunction

    function [7:0] cnt(input [2:0] k);
        cnt = `CNT_OFF + {3'h0, k, 2'h0};
    endfunction

    // Bready and rready stay high, so the answer is taken when it shows.
    task wr(input [7:0] a, input [31:0] d);
        integer n;
    begin
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge clock);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        r = bresp;
        tmo(n);
    end
    endtask

    task rd(input [7:0] a, output [31:0] d);
        integer n;
    begin
        ara <= a;
        arv <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge clock);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        d = rdata;
        r = rresp;
        tmo(n);
    end
    endtask

    task chkr(input [7:0] a, input [31:0] e);
    begin
        rd(a, v);
        `CHK(v, e)
    end
    endtask

    task pls(input integer k);
    begin
        tin[k] <= 1'b1;
        repeat (4) @(posedge clock);
        tin[k] <= 1'b0;
        repeat (4) @(posedge clock);
    end
    endtask

    // Runs a timer for a window and checks the count lands in a range.
    task rng(input [2:0] k, input [31:0] c, input integer lo, hi);
    begin
        wr(cnt(k), 32'h0);
        wr(ctl(k), c);
        repeat (80) @(posedge clock);
        wr(ctl(k), 32'h0);
        rd(cnt(k), v);
        `CHK(v >= lo && v <= hi, 1'b1)
    end
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        for (i = 0; i < 5; i++)
        begin
            chkr(ctl(i[2:0]), 32'h0);
            wr(cnt(i[2:0]), 32'hBEEF_A500 + i);
            chkr(cnt(i[2:0]), 32'h0000_A500 + i);
        end
        chkr(`IRQ_STAT_OFF, 32'h0);
        rd(8'h80, v);
        `CHK({r, v}, {`RESP_SLVERR, 32'h0})
        wr(8'h80, 32'h1);
        `CHK(r, `RESP_SLVERR)
        rng(3'h1, 32'h40, 9, 12);
        rng(3'h4, 32'h40, 19, 23);
        rng(3'h2, 32'h58, 0, 0);
        tin[2] <= 1'b1;
        rng(3'h2, 32'h58, 8, 12);
        tin[2] <= 1'b0;
        // Underflow of the second module core timer, first masked.
        wr(cnt(3'h4), 32'h1);
        wr(ctl(3'h4), 32'h08C0);
        for (i = 0; i < 200 && cpul !== 1'b1; i++) @(posedge clock);
        tmo(i);
        @(posedge clock);
        `CHK(cpul, 1'b0)
        repeat (2) @(posedge clock);
        `CHK(t6o, 1'b1)
        `CHK(irq, 1'b0)
        wr(ctl(3'h4), 32'h0);
        chkr(`IRQ_STAT_OFF, 32'h10);
        wr(`IRQ_MASK_OFF, 32'h10);
        repeat (2) @(posedge clock);
        `CHK(irq, 1'b1)
        wr(`IRQ_STAT_OFF, 32'h10);
        repeat (2) @(posedge clock);
        `CHK(irq, 1'b0)
        chkr(`IRQ_STAT_OFF, 32'h0);
        // Counter mode on pin edges, then the direction pin turns it round.
        wr(cnt(3'h0), 32'h0);
        wr(ctl(3'h0), 32'h248);
        for (i = 0; i < 5; i++) pls(0);
        chkr(cnt(3'h0), 32'h5);
        dir[0] <= 1'b1;
        wr(ctl(3'h0), 32'h348);
        for (i = 0; i < 3; i++) pls(0);
        chkr(cnt(3'h0), 32'h2);
        // Capture of the core timer, then reload of it.
        wr(cnt(3'h1), 32'h5A5A);
        wr(ctl(3'h0), 32'h268);
        pls(0);
        repeat (40) @(posedge clock);
        chkr(cnt(3'h0), 32'h5A5A);
        wr(cnt(3'h2), 32'h1111);
        wr(ctl(3'h2), 32'h2220);
        pls(2);
        chkr(cnt(3'h1), 32'h1111);
        // Capture register takes the module two aux timer and clears it.
        wr(cnt(3'h3), 32'h0777);
        wr(ctl(3'h3), 32'h6000);
        cap <= 1'b1;
        repeat (6) @(posedge clock);
        chkr(`CAPTURE_RELOAD_REGISTER_OFF, 32'h0777);
        chkr(cnt(3'h3), 32'h0);
        chkr(`IRQ_STAT_OFF, 32'h20);
        // Module two core underflow reloads it from the capture register.
        wr(cnt(3'h4), 32'h0);
        wr(ctl(3'h4), 32'h10C0);
        for (i = 0; i < 200 && cpul !== 1'b1; i++) @(posedge clock);
        tmo(i);
        wr(ctl(3'h4), 32'h0);
        rd(cnt(3'h4), v);
        `CHK(v >= 32'h770 && v <= 32'h777, 1'b1)
        // Core latch toggles on overflow and clocks the chained aux timer.
        wr(cnt(3'h2), 32'h0);
        wr(ctl(3'h2), 32'h1648);
        wr(cnt(3'h1), 32'hFFFF);
        wr(ctl(3'h1), 32'h0840);
        repeat (40) @(posedge clock);
        `CHK(t3o, 1'b1)
        wr(ctl(3'h1), 32'h0);
        chkr(cnt(3'h2), 32'h1);
        finish_test;
    end
endmodule
